// *** core/lpm_defs.svh ***
`ifndef LPM_DEFS_SVH
`define LPM_DEFS_SVH
`define LPM_NUM_BANKS       4
`define LPM_CLK_PERIOD_NS   10
`define LPM_XP_NS           20
`define LPM_XP_CYC          ((`LPM_XP_NS + `LPM_CLK_PERIOD_NS - 1) / `LPM_CLK_PERIOD_NS)
`define LPM_RESTART_CYC     1
`endif

// *** core/lpm_pkg.sv ***
package lpm_pkg;
   typedef enum logic [2:0] {
      LPM_IDLE,
      LPM_ACTIVE,
      LPM_PD_PRE,
      LPM_PD_ACT,
      LPM_DEEP_PD,
      LPM_EXIT_WAIT,
      LPM_UNINIT
   } lpm_state_e;
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
   } lpm_cmd_s;
   typedef struct packed {
      logic       activate;
      logic       precharge;
      logic       precharge_all;
      logic [1:0] bank;
      logic       col_busy;
   } lpm_core_s;
endpackage

// *** core/lpm_power_ctrl.sv ***
// Function
// RQ1 - Host keeps pulse or exit latency times
// RQ2 - Idle banks give precharge, open gives active
// RQ3 - Host never drops clock enable mid access
// RQ4 - Deep power-down clears all array contents
// RQ5 - Host precharges and quiets bus first
// RQ6 - Decode deep power-down with clock enable low
// RQ7 - Host holds clock enable low throughout
// RQ8 - Exit deep power-down on raise with nop
// RQ9 - Host reinitializes after deep power-down exit
// RQ10 - Host changes frequency only within timing
// RQ11 - Host stops clock only when quiet
// RQ12 - Clock stop holds enable high, clock low
// RQ13 - After restart one nop before commands
// RQ14 - Enter power-down, gate buffers except enable
// RQ15 - Exit power-down on enable high with nop
`timescale 1ns/1ps
`include "lpm_defs.svh"
module lpm_power_ctrl #(
   parameter int XP_CYC = `LPM_XP_CYC
) (
   // Clock and reset
   input  wire logic               ref_clk,
   input  wire logic               rstn,
   // Pins from host
   input  wire logic               cke,
   input  wire lpm_pkg::lpm_cmd_s  cmd,
   // Core bank events
   input  wire lpm_pkg::lpm_core_s core,
   // Status
   output logic                    buffers_on,
   output logic                    array_powered,
   output logic                    array_clear,
   output logic                    cmd_accept,
   output lpm_pkg::lpm_state_e     state
);
   import lpm_pkg::*;
   logic                     cke_m_q, cke_q;
   lpm_cmd_s                 cmd_m_q, cmd_q;
   lpm_state_e               st_q, st_d;
   logic [`LPM_NUM_BANKS-1:0] open_q, open_d;
   logic [7:0]               xp_q, xp_d;
   logic                     cke_prev_q;
   logic                     clr_q;
   lpm_state_e               back_q;
   wire is_nop   = cmd_q.cs_n | (cmd_q.ras_n & cmd_q.cas_n & cmd_q.we_n);
   wire is_dpd   = ~cmd_q.cs_n & cmd_q.ras_n & cmd_q.cas_n & ~cmd_q.we_n;
   wire any_open = |open_d;
   wire cke_fall = cke_prev_q & ~cke_q;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cke_m_q <= 1'b0;
         cke_q   <= 1'b0;
         cmd_m_q <= '1;
         cmd_q   <= '1;
      end else begin
         cke_m_q <= cke;
         cke_q   <= cke_m_q;
         cmd_m_q <= cmd;
         cmd_q   <= cmd_m_q;
      end
   end
   // Per bank open row tracking
   genvar b;
   generate
      for (b = 0; b < `LPM_NUM_BANKS; b++) begin : g_bank
         always_comb begin
            open_d[b] = open_q[b];
            if (st_q == LPM_DEEP_PD)
               open_d[b] = 1'b0;
            else if (core.precharge_all || (core.precharge && core.bank == 2'(b)))
               open_d[b] = 1'b0;
            else if (core.activate && core.bank == 2'(b))
               open_d[b] = 1'b1;
         end
      end
   endgenerate
   always_comb begin
      st_d = st_q;
      xp_d = (xp_q != 8'h00) ? xp_q - 8'h01 : 8'h00;
      unique case (st_q)
         LPM_UNINIT, LPM_IDLE, LPM_ACTIVE: begin
            if (cke_fall && is_dpd && !any_open)
               st_d = LPM_DEEP_PD; // RQ6
            else if (cke_fall)
               st_d = any_open ? LPM_PD_ACT : LPM_PD_PRE; // RQ2 RQ14
            else if (st_q != LPM_UNINIT)
               st_d = any_open ? LPM_ACTIVE : LPM_IDLE;
         end
         LPM_PD_PRE, LPM_PD_ACT: begin
            if (cke_q && is_nop) begin
               st_d = LPM_EXIT_WAIT; // RQ15
               xp_d = 8'(XP_CYC);
            end
         end
         LPM_DEEP_PD: begin
            if (cke_q && is_nop)
               st_d = LPM_UNINIT; // RQ8
         end
         LPM_EXIT_WAIT: begin
            if (xp_q <= 8'h01)
               st_d = back_q;
         end
      endcase
   end
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_q       <= LPM_UNINIT;
         open_q     <= '0;
         xp_q       <= 8'h00;
         cke_prev_q <= 1'b0;
         clr_q      <= 1'b0;
         back_q     <= LPM_IDLE;
      end else begin
         st_q       <= st_d;
         open_q     <= open_d;
         xp_q       <= xp_d;
         cke_prev_q <= cke_q;
         clr_q      <= (st_d == LPM_DEEP_PD) && (st_q != LPM_DEEP_PD); // RQ4
         if (st_q == LPM_PD_ACT)
            back_q <= LPM_ACTIVE;
         else if (st_q == LPM_PD_PRE)
            back_q <= LPM_IDLE;
      end
   end
   assign state         = st_q;
   assign buffers_on    = !(st_q inside {LPM_PD_PRE, LPM_PD_ACT, LPM_DEEP_PD}); // RQ14
   assign array_powered = (st_q != LPM_DEEP_PD); // RQ4
   assign array_clear   = clr_q;
   assign cmd_accept    = (st_q inside {LPM_IDLE, LPM_ACTIVE, LPM_UNINIT});
   // Checks
   property p_pd_kind;
      @(posedge ref_clk) disable iff (!rstn)
      (st_q inside {LPM_UNINIT, LPM_IDLE, LPM_ACTIVE} && cke_fall && !(is_dpd && !any_open))
         |=> (st_q == (($past(any_open)) ? LPM_PD_ACT : LPM_PD_PRE));
   endproperty
   a_pd_kind: assert property (p_pd_kind) else $error("wrong power-down kind"); // RQ2
   property p_dpd_entry;
      @(posedge ref_clk) disable iff (!rstn)
      (st_q inside {LPM_UNINIT, LPM_IDLE, LPM_ACTIVE} && cke_fall && is_dpd && !any_open)
         |=> st_q == LPM_DEEP_PD;
   endproperty
   a_dpd_entry: assert property (p_dpd_entry) else $error("deep entry missed"); // RQ6
   property p_dpd_clear;
      @(posedge ref_clk) disable iff (!rstn)
      $rose(st_q == LPM_DEEP_PD) |-> array_clear && !array_powered && open_q == '0;
   endproperty
   a_dpd_clear: assert property (p_dpd_clear) else $error("array not cleared"); // RQ4
   property p_dpd_exit;
      @(posedge ref_clk) disable iff (!rstn)
      (st_q == LPM_DEEP_PD && cke_q && is_nop) |=> st_q == LPM_UNINIT;
   endproperty
   a_dpd_exit: assert property (p_dpd_exit) else $error("deep exit missed"); // RQ8
   property p_dpd_hold;
      @(posedge ref_clk) disable iff (!rstn)
      (st_q == LPM_DEEP_PD && !cke_q) |=> st_q == LPM_DEEP_PD;
   endproperty
   a_dpd_hold: assert property (p_dpd_hold) else $error("deep left early"); // RQ8
   property p_buf_off;
      @(posedge ref_clk) disable iff (!rstn)
      (st_q inside {LPM_PD_PRE, LPM_PD_ACT}) |-> !buffers_on && !cmd_accept;
   endproperty
   a_buf_off: assert property (p_buf_off) else $error("buffers on in power-down"); // RQ14
   property p_pd_exit;
      @(posedge ref_clk) disable iff (!rstn)
      (st_q inside {LPM_PD_PRE, LPM_PD_ACT} && cke_q && is_nop)
         |=> st_q == LPM_EXIT_WAIT ##[1:255] cmd_accept;
   endproperty
   a_pd_exit: assert property (p_pd_exit) else $error("power-down exit slow"); // RQ15
   // Cycles spent waiting out the exit latency, counted apart from the down counter
   logic [7:0]               wait_cnt_q;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn)
         wait_cnt_q <= 8'h00;
      else if (st_q == LPM_EXIT_WAIT)
         wait_cnt_q <= wait_cnt_q + 8'h01;
      else
         wait_cnt_q <= 8'h00;
   end
   property p_xp_wait;
      @(posedge ref_clk) disable iff (!rstn)
      (st_q == LPM_EXIT_WAIT && st_d != LPM_EXIT_WAIT) |-> wait_cnt_q == 8'(XP_CYC - 1);
   endproperty
   a_xp_wait: assert property (p_xp_wait) else $error("exit latency length wrong"); // RQ15
   property p_refuse_dpd;
      @(posedge ref_clk) disable iff (!rstn)
      (st_q inside {LPM_UNINIT, LPM_IDLE, LPM_ACTIVE} && cke_fall && is_dpd && any_open)
         |=> st_q == LPM_PD_ACT;
   endproperty
   a_refuse_dpd: assert property (p_refuse_dpd) else $error("deep entry with open row"); // RQ2
   property p_entry_off;
      @(posedge ref_clk) disable iff (!rstn)
      (st_q inside {LPM_UNINIT, LPM_IDLE, LPM_ACTIVE} && cke_fall) |=> !buffers_on && !cmd_accept;
   endproperty
   a_entry_off: assert property (p_entry_off) else $error("buffers on after entry"); // RQ14
   property p_clear_once;
      @(posedge ref_clk) disable iff (!rstn)
      array_clear |=> !array_clear;
   endproperty
   a_clear_once: assert property (p_clear_once) else $error("clear pulse too long"); // RQ4
   property p_open_lost;
      @(posedge ref_clk) disable iff (!rstn)
      (st_q == LPM_DEEP_PD) |=> open_q == '0;
   endproperty
   a_open_lost: assert property (p_open_lost) else $error("row kept in deep mode"); // RQ4
   property p_pd_stay;
      @(posedge ref_clk) disable iff (!rstn)
      (st_q inside {LPM_PD_PRE, LPM_PD_ACT} && !(cke_q && is_nop)) |=> $stable(st_q);
   endproperty
   a_pd_stay: assert property (p_pd_stay) else $error("power-down left early"); // RQ15
   property p_uninit_hold;
      @(posedge ref_clk) disable iff (!rstn)
      (st_q == LPM_UNINIT && !cke_fall) |=> st_q == LPM_UNINIT;
   endproperty
   a_uninit_hold: assert property (p_uninit_hold) else $error("left uninit early"); // RQ8
   property p_back_kind;
      @(posedge ref_clk) disable iff (!rstn)
      (st_q == LPM_EXIT_WAIT && st_d != LPM_EXIT_WAIT) |=> st_q inside {LPM_IDLE, LPM_ACTIVE};
   endproperty
   a_back_kind: assert property (p_back_kind) else $error("wrong state after exit"); // RQ15
   c_pd_act: cover property (@(posedge ref_clk) disable iff (!rstn) st_q == LPM_PD_ACT);
   c_pd_pre: cover property (@(posedge ref_clk) disable iff (!rstn) st_q == LPM_PD_PRE);
   c_dpd:    cover property (@(posedge ref_clk) disable iff (!rstn)
                             st_q == LPM_DEEP_PD ##[1:20] st_q == LPM_UNINIT);
   c_xp:     cover property (@(posedge ref_clk) disable iff (!rstn)
                             st_q == LPM_EXIT_WAIT ##1 st_q == LPM_ACTIVE);
endmodule

// *** verification/lpm_host_model.sv ***
`timescale 1ns/1ps
module lpm_host_model (
   // Clock
   input  wire logic        ref_clk,
   // Pins to device
   output logic             cke,
   output lpm_pkg::lpm_cmd_s cmd
);
   import lpm_pkg::*;
   // Clock enable starts high so reset release sees no entry
   initial begin
      cke = 1'b1;
      cmd = 4'h7;
   end
   // Pins change only after the falling edge and hold until the next call
   task automatic pins(input logic c, input lpm_cmd_s k);
      @(negedge ref_clk);
      cke = c;
      cmd = k;
   endtask
endmodule

// *** verification/lpm_power_ctrl_bench.sv ***
`timescale 1ns/1ps
module lpm_power_ctrl_bench;
   import lpm_pkg::*;
   localparam lpm_cmd_s NOP  = 4'h7;
   localparam lpm_cmd_s DEEP = 4'h6;
   localparam lpm_cmd_s ACT  = 4'h3;
   localparam int       XP   = 2;
   logic       ref_clk;
   logic       clk_run = 1'b1;
   int         half_ns = 5;
   logic       rstn;
   logic       cke;
   lpm_cmd_s   cmd;
   lpm_core_s  core;
   logic       buffers_on;
   logic       array_powered;
   logic       array_clear;
   logic       cmd_accept;
   lpm_state_e state;
   int         error_cnt;
   int         n_tests;
   lpm_host_model host (.ref_clk(ref_clk), .cke(cke), .cmd(cmd));
   lpm_power_ctrl #(.XP_CYC(XP)) dut (.ref_clk(ref_clk), .rstn(rstn), .cke(cke), .cmd(cmd),
      .core(core), .buffers_on(buffers_on), .array_powered(array_powered),
      .array_clear(array_clear), .cmd_accept(cmd_accept), .state(state));
   initial begin
      ref_clk = 1'b0;
      // Stopped clock rests low
      forever #(half_ns) ref_clk = clk_run ? ~ref_clk : 1'b0;
   end
   task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wait_st(input lpm_state_e s);
      for (int i = 0; i < 12 && state !== s; i++) @(negedge ref_clk);
      chk("state", state, s);
   endtask
   task automatic pulse(input lpm_core_s v);
      @(negedge ref_clk);
      core = v;
      @(negedge ref_clk);
      core = '0;
   endtask
   task automatic t_pre;
      int n;
      host.pins(1'b0, NOP);
      wait_st(LPM_PD_PRE);
      chk("buffers_on", buffers_on, 0);
      chk("cmd_accept", cmd_accept, 0);
      host.pins(1'b1, NOP);
      wait_st(LPM_EXIT_WAIT);
      n = 0;
      while (state === LPM_EXIT_WAIT) begin
         n++;
         @(negedge ref_clk);
      end
      chk("exit_cycles", n, XP);
      wait_st(LPM_IDLE);
      chk("cmd_accept", cmd_accept, 1);
      chk("buffers_on", buffers_on, 1);
   endtask
   task automatic t_act;
      pulse(6'h22);
      host.pins(1'b0, DEEP);
      wait_st(LPM_PD_ACT);
      chk("array_powered", array_powered, 1);
      host.pins(1'b1, NOP);
      wait_st(LPM_ACTIVE);
   endtask
   task automatic t_deep;
      pulse(6'h12);
      host.pins(1'b0, DEEP);
      host.pins(1'b0, NOP);
      wait_st(LPM_DEEP_PD);
      chk("array_powered", array_powered, 0);
      chk("array_clear", array_clear, 1);
      @(negedge ref_clk);
      chk("array_clear", array_clear, 0);
      host.pins(1'b1, ACT);
      repeat (6) @(negedge ref_clk);
      chk("state", state, LPM_DEEP_PD);
      host.pins(1'b1, NOP);
      wait_st(LPM_UNINIT);
   endtask
   task automatic t_stop;
      host.pins(1'b1, NOP);
      clk_run = 1'b0;
      #203;
      chk("state", state, LPM_UNINIT);
      half_ns = 10;
      clk_run = 1'b1;
      host.pins(1'b1, NOP);
      @(negedge ref_clk);
      host.pins(1'b0, NOP);
      wait_st(LPM_PD_PRE);
      host.pins(1'b1, NOP);
      wait_st(LPM_IDLE);
      half_ns = 5;
   endtask
   task automatic t_reset;
      pulse(6'h20);
      wait_st(LPM_ACTIVE);
      rstn = 1'b0;
      @(negedge ref_clk);
      chk("state", state, LPM_UNINIT);
      chk("buffers_on", buffers_on, 1);
      chk("array_powered", array_powered, 1);
      chk("array_clear", array_clear, 0);
      chk("cmd_accept", cmd_accept, 1);
      rstn = 1'b1;
      repeat (3) @(negedge ref_clk);
      chk("state", state, LPM_UNINIT);
      host.pins(1'b0, NOP);
      wait_st(LPM_PD_PRE);
      host.pins(1'b1, NOP);
      wait_st(LPM_IDLE);
   endtask
   task automatic final_report;
      $display("Tests %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #20000;
      error_cnt++;
      final_report();
   end
   initial begin
      rstn = 1'b0;
      core = '0;
      error_cnt = 0;
      n_tests = 0;
      repeat (5) @(negedge ref_clk);
      rstn = 1'b1;
      repeat (4) @(negedge ref_clk);
      t_pre();
      t_act();
      t_deep();
      t_stop();
      t_reset();
      final_report();
   end
endmodule
